// *** hdl/watchdog_pkg.sv ***
package watchdog_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS   = 100;
	localparam int CLK_HZ          = 10_000_000;
	localparam int TICK_US_NS      = 1_000;
	localparam int TICK_MS_NS      = 1_000_000;
	localparam int SIM_CLK_HZ      = 1_000_000;
	localparam int US_TICK_CYCLES  = (TICK_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MS_TICK_CYCLES  = (TICK_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SIM_TICK_CYCLES = CLK_HZ / SIM_CLK_HZ;
	localparam int TICK_CNT_W      = 16;

	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam logic [15:0] ADDR_CTRL_LO = 16'h3000;
	localparam logic [15:0] ADDR_CTRL_HI = 16'h3001;
	localparam logic [15:0] ADDR_KICK    = 16'h3002;
	localparam logic [15:0] ADDR_COUNT   = 16'h3004;
	localparam logic [15:0] ADDR_LOAD    = 16'h3008;

	// ----------------------------------------
	// Control fields and reset values
	// ----------------------------------------
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          CTRL_STS_BIT  = 1;
	localparam int          CTRL_SIM_BIT  = 2;
	localparam int          CTRL_UNIT_BIT = 3;
	localparam logic [31:0] COUNT_RESET   = 32'hFFFF_FFFF;
	localparam logic [31:0] LOAD_RESET    = 32'hFFFF_FFFF;
	localparam logic [31:0] COUNT_ZERO    = 32'h0000_0000;
	localparam logic [31:0] COUNT_STEP    = 32'h0000_0001;
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;

	// Byte-wide register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} reg_req_t;

	// Address falls in the aligned word at base
	function automatic logic in_word(input logic [15:0] addr, input logic [15:0] base);
		return addr[15:2] == base[15:2];
	endfunction

	// Select one byte of a word
	function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] lane);
		return w[lane*8 +: 8];
	endfunction

	// Replace one byte of a word
	function automatic logic [31:0] set_byte(input logic [31:0] w, input logic [1:0] lane, input logic [7:0] b);
		logic [31:0] r;
		r = w;
		r[lane*8 +: 8] = b;
		return r;
	endfunction

endpackage

// *** hdl/input_sync.sv ***
`timescale 1ns/10ps
module input_sync
	import watchdog_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset_n,
	// Pin side
	input  wire logic pin_in,
	// Core side
	output logic      level
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} sync_state_t;

	sync_state_t cur;
	sync_state_t next_cur;

	// Three stages; a change counts once the second and third agree
	always_comb begin
		next_cur    = cur;
		next_cur.s1 = pin_in;
		next_cur.s2 = cur.s1;
		next_cur.s3 = cur.s2;
		if (cur.s2 == cur.s3) begin
			next_cur.level = cur.s3;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign level = cur.level;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_sync_agree;
		@(posedge core_clk) disable iff (!reset_n)
		$changed(level) |-> $past(cur.s2) == $past(cur.s3);
	endproperty
	a_sync_agree: assert property (p_sync_agree) else $error("sync level changed without agreement");

endmodule // input_sync

// *** hdl/tick_gen.sv ***
`timescale 1ns/10ps
module tick_gen
	import watchdog_pkg::*;
#(
	parameter int US_CYCLES  = US_TICK_CYCLES,
	parameter int MS_CYCLES  = MS_TICK_CYCLES,
	parameter int SIM_CYCLES = SIM_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset_n,
	// Control
	input  wire logic run,
	input  wire logic sel_us,
	input  wire logic sel_sim,
	// Tick out
	output logic      tick
);

	typedef struct packed {
		logic [TICK_CNT_W-1:0] cnt;
		logic                  tick;
	} tick_state_t;

	tick_state_t           cur;
	tick_state_t           next_cur;
	logic [TICK_CNT_W-1:0] last;

	// Divider held at zero while stopped, standing in for a gated clock
	always_comb begin
		next_cur      = cur;
		next_cur.tick = 1'b0;
		if (sel_sim) begin
			last = TICK_CNT_W'(SIM_CYCLES - 1);
		end else if (sel_us) begin
			last = TICK_CNT_W'(US_CYCLES - 1);
		end else begin
			last = TICK_CNT_W'(MS_CYCLES - 1);
		end
		if (!run) begin
			next_cur.cnt = '0;
		end else if (cur.cnt >= last) begin
			next_cur.cnt  = '0;
			next_cur.tick = 1'b1;
		end else begin
			next_cur.cnt = cur.cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign tick = cur.tick;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_us_period;
		@(posedge core_clk) disable iff (!reset_n)
		tick && run && (sel_us || sel_sim) && $stable(sel_us) |=> (!tick)[*8];
	endproperty
	a_us_period: assert property (p_us_period) else $error("fast tick came early");

	property p_stopped_quiet;
		@(posedge core_clk) disable iff (!reset_n)
		!run |=> !tick;
	endproperty
	a_stopped_quiet: assert property (p_stopped_quiet) else $error("tick while stopped");

endmodule // tick_gen

// *** hdl/watchdog_timer_regs.sv ***
`timescale 1ns/10ps
module watchdog_timer_regs
	import watchdog_pkg::*;
#(
	parameter int MS_CYCLES = MS_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	// Register port
	input  wire watchdog_pkg::reg_req_t reg_req,
	output logic [7:0]             rd_data,
	// Reset generator
	input  wire logic              wdt_reset_flag,
	output logic                   system_reset_req,
	// Oscillator control
	output logic                   fast_osc_enable
);
	import watchdog_pkg::*;

	typedef struct packed {
		logic        unit_us;
		logic        sim;
		logic        status;
		logic        enable;
		logic        en_q;
		logic        kick_q;
		logic        flag_prev;
		logic        reset_req;
		logic [31:0] load;
		logic [31:0] count;
		logic [31:0] snap;
		logic [7:0]  rd_data;
	} wdt_state_t;

	wdt_state_t cur;
	wdt_state_t next_cur;
	logic       tick;
	logic       flag_level;
	logic       wr_ok;
	logic       sts_clear;
	logic       sts_set;
	logic       underflow;
	logic       load_wr;
	logic [7:0] ctrl_rd;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Reset cause arrives from the reset generator, another domain
	input_sync u_flag_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.pin_in   (wdt_reset_flag),
		.level    (flag_level)
	);

	// Tick follows the synchronised enable, not the raw bit
	tick_gen #(
		.MS_CYCLES (MS_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.run      (cur.en_q),
		.sel_us   (cur.unit_us),
		.sel_sim  (cur.sim),
		.tick     (tick)
	);

	// ----------------------------------------
	// Register and counter logic
	// ----------------------------------------
	always_comb begin
		next_cur         = cur;
		next_cur.rd_data = BYTE_ZERO;
		next_cur.kick_q  = 1'b0;
		next_cur.en_q    = cur.enable;
		// Pending status locks out writes except the clear itself
		// write lockout
		wr_ok     = reg_req.wr && !cur.status;
		sts_clear = 1'b0;
		load_wr   = 1'b0;
		ctrl_rd                = BYTE_ZERO;
		ctrl_rd[CTRL_EN_BIT]   = cur.enable;
		ctrl_rd[CTRL_STS_BIT]  = cur.status;
		ctrl_rd[CTRL_SIM_BIT]  = cur.sim;
		ctrl_rd[CTRL_UNIT_BIT] = cur.unit_us;

		// Reads; kick, control high byte and unmapped bytes give zero
		// zero reads
		if (reg_req.rd) begin
			if (reg_req.addr == ADDR_CTRL_LO) begin
				next_cur.rd_data = ctrl_rd;
			end else if (in_word(reg_req.addr, ADDR_COUNT)) begin
				if (reg_req.addr[1:0] == 2'h0) begin
					next_cur.snap    = cur.count;
					next_cur.rd_data = get_byte(cur.count, 2'h0);
				end else begin
					next_cur.rd_data = get_byte(cur.snap, reg_req.addr[1:0]);
				end
			end else if (in_word(reg_req.addr, ADDR_LOAD)) begin
				next_cur.rd_data = get_byte(cur.load, reg_req.addr[1:0]);
			end
		end

		if (reg_req.wr && reg_req.addr == ADDR_CTRL_LO) begin
			sts_clear = reg_req.wdata[CTRL_STS_BIT];
		end

		// Writes; reserved space and read-only count are ignored
		// address decode
		if (wr_ok) begin
			if (reg_req.addr == ADDR_CTRL_LO) begin
				next_cur.enable  = reg_req.wdata[CTRL_EN_BIT];
				next_cur.sim     = reg_req.wdata[CTRL_SIM_BIT];
				next_cur.unit_us = reg_req.wdata[CTRL_UNIT_BIT];
			end else if (reg_req.addr == ADDR_KICK) begin
				next_cur.kick_q = cur.enable;
			end else if (in_word(reg_req.addr, ADDR_LOAD) && !cur.enable) begin
				next_cur.load = set_byte(cur.load, reg_req.addr[1:0], reg_req.wdata);
				load_wr       = 1'b1;
			end
		end

		underflow = tick && cur.en_q && (cur.count == COUNT_ZERO);

		// Counter: load write, activation, kick, then tick
		// reload and count
		if (load_wr) begin
			next_cur.count = next_cur.load;
		end else if (cur.enable && !cur.en_q) begin
			next_cur.count = cur.load;
		end else if (cur.en_q && cur.kick_q) begin
			next_cur.count = cur.load;
		end else if (underflow) begin
			next_cur.count = cur.load;
		end else if (tick && cur.en_q) begin
			next_cur.count = cur.count - COUNT_STEP;
		end

		// Reset request holds until the device reset takes it down
		if (underflow) begin
			next_cur.reset_req = 1'b1;
		end

		// A set in the same cycle as a clear wins
		// status set
		next_cur.flag_prev = flag_level;
		sts_set = underflow || (flag_level && !cur.flag_prev);
		if (sts_clear) begin
			next_cur.status = 1'b0;
		end
		if (sts_set) begin
			next_cur.status = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur       <= '0;
			cur.load  <= LOAD_RESET;
			cur.count <= COUNT_RESET;
			cur.snap  <= COUNT_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rd_data          = cur.rd_data;
	assign system_reset_req = cur.reset_req;
	assign fast_osc_enable  = cur.en_q && (cur.unit_us || cur.sim);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	property p_underflow_sets;
		underflow |=> cur.status && system_reset_req && cur.count == $past(cur.load);
	endproperty
	a_underflow_sets: assert property (p_underflow_sets) else $error("underflow did not raise status and reset");

	property p_clear_cause;
		$fell(cur.status) |-> $past(reg_req.wr) && $past(reg_req.addr) == ADDR_CTRL_LO
			&& $past(reg_req.wdata[CTRL_STS_BIT]);
	endproperty
	a_clear_cause: assert property (p_clear_cause) else $error("status fell without write of one");

	property p_kick_reload;
		reg_req.wr && reg_req.addr == ADDR_KICK && !cur.status && cur.enable && cur.en_q
			|=> ##1 cur.count == $past(cur.load, 2);
	endproperty
	a_kick_reload: assert property (p_kick_reload) else $error("kick did not reload counter");

	property p_kick_ignored;
		cur.kick_q |-> $past(cur.enable);
	endproperty
	a_kick_ignored: assert property (p_kick_ignored) else $error("kick taken while disabled");

	property p_kick_reads_zero;
		reg_req.rd && reg_req.addr == ADDR_KICK |=> rd_data == BYTE_ZERO;
	endproperty
	a_kick_reads_zero: assert property (p_kick_reads_zero) else $error("kick read not zero");

	property p_upper_from_snap;
		reg_req.rd && in_word(reg_req.addr, ADDR_COUNT) && reg_req.addr[1:0] != 2'h0
			|=> rd_data == get_byte($past(cur.snap), $past(reg_req.addr[1:0]));
	endproperty
	a_upper_from_snap: assert property (p_upper_from_snap) else $error("upper count byte not from snapshot");

	property p_snapshot;
		reg_req.rd && reg_req.addr == ADDR_COUNT |=> cur.snap == $past(cur.count);
	endproperty
	a_snapshot: assert property (p_snapshot) else $error("low byte read did not snapshot");

	property p_decrement;
		tick && cur.en_q && cur.enable && !cur.kick_q && !load_wr && cur.count != COUNT_ZERO
			|=> cur.count == $past(cur.count) - COUNT_STEP;
	endproperty
	a_decrement: assert property (p_decrement) else $error("counter did not step down on tick");

	property p_blocked;
		cur.status && reg_req.wr |=> $stable(cur.load) && $stable(cur.enable) && $stable(cur.unit_us);
	endproperty
	a_blocked: assert property (p_blocked) else $error("write taken while status pending");

	property p_load_locked;
		cur.enable |=> $stable(cur.load);
	endproperty
	a_load_locked: assert property (p_load_locked) else $error("load changed while enabled");

	property p_load_reload;
		load_wr |=> cur.count == cur.load;
	endproperty
	a_load_reload: assert property (p_load_reload) else $error("load write did not copy into count");

	property p_activation_reload;
		cur.enable && !cur.en_q |=> cur.count == $past(cur.load);
	endproperty
	a_activation_reload: assert property (p_activation_reload) else $error("enable did not reload count");

	property p_enable_lag;
		$rose(cur.enable) |-> !cur.en_q ##1 cur.en_q;
	endproperty
	a_enable_lag: assert property (p_enable_lag) else $error("enable did not reach counter one cycle later");

	property p_stopped_hold;
		!cur.enable && !cur.en_q && !load_wr |=> $stable(cur.count);
	endproperty
	a_stopped_hold: assert property (p_stopped_hold) else $error("stopped counter moved");

	property p_status_set_wins;
		sts_set |=> cur.status;
	endproperty
	a_status_set_wins: assert property (p_status_set_wins) else $error("status not set after cause");

	property p_ctrl_hi_zero;
		reg_req.rd && reg_req.addr == ADDR_CTRL_HI |=> rd_data == BYTE_ZERO;
	endproperty
	a_ctrl_hi_zero: assert property (p_ctrl_hi_zero) else $error("control high byte not zero");

	c_underflow: cover property (underflow);
	c_kick: cover property (cur.kick_q && cur.en_q);
	c_status_clear: cover property ($fell(cur.status));
	c_blocked_write: cover property (cur.status && reg_req.wr);
	c_snapshot_read: cover property (reg_req.rd && reg_req.addr == ADDR_COUNT ##1 reg_req.rd);

endmodule // watchdog_timer_regs

// *** tb/reset_source.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Reset generator standing beside the watchdog
// ----------------------------------------
module reset_source (
	// Clock and power-on reset
	input  wire logic core_clk,
	input  wire logic por_n,
	// Request from the watchdog
	input  wire logic system_reset_req,
	// Reset and cause to the device
	output logic      reset_n,
	output logic      wdt_reset_flag
);
	logic [2:0] hold;

	// cause is remembered
	// Stretch a request into a short reset; the cause flag survives it, only power-on clears it
	always_ff @(posedge core_clk or negedge por_n) begin
		if (!por_n) begin
			hold <= 3'h0;
			wdt_reset_flag <= 1'b0;
		end else if (system_reset_req && hold == 3'h0) begin
			hold <= 3'h4;
			wdt_reset_flag <= 1'b1;
		end else if (hold != 3'h0) begin
			hold <= hold - 3'h1;
		end
	end

	// Registered hold keeps the reset free of glitches
	assign reset_n = por_n && (hold == 3'h0);
endmodule // reset_source

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
	import watchdog_pkg::*;
	localparam int MS_CYC = 20;
	localparam int SPAN   = 200;

	logic        core_clk;
	logic        por_n;
	logic        reset_n;
	reg_req_t    reg_req;
	logic [7:0]  rd_data;
	logic        wdt_reset_flag;
	logic        system_reset_req;
	logic        fast_osc_enable;
	int          mismatches;
	int          checks;
	logic [31:0] v;
	logic [7:0]  a;
	logic [7:0]  b;
	int          n;

	// Short millisecond divider keeps the run brief
	watchdog_timer_regs #(.MS_CYCLES(MS_CYC)) dut_u (
		.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req), .rd_data(rd_data),
		.wdt_reset_flag(wdt_reset_flag), .system_reset_req(system_reset_req), .fast_osc_enable(fast_osc_enable));
	reset_source src_u (.core_clk(core_clk), .por_n(por_n), .system_reset_req(system_reset_req),
		.reset_n(reset_n), .wdt_reset_flag(wdt_reset_flag));

	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	// ----------------------------------------
	// Access and compare tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One-cycle strobe; the idle cycle after it keeps drivers from colliding
	task automatic wr(input logic [15:0] addr, input logic [7:0] d);
		@(posedge core_clk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
		@(posedge core_clk);
		reg_req <= '0;
	endtask

	// Data is registered on the sampling edge, taken just after it
	task automatic rd(input logic [15:0] addr, output logic [7:0] d);
		@(posedge core_clk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge core_clk);
		reg_req <= '0;
		#1 d = rd_data;
	endtask

	// Low byte first, so the snapshot covers the whole word
	task automatic rd32(input logic [15:0] base, output logic [31:0] w);
		logic [7:0] x;
		for (int i = 0; i < 4; i++) begin
			rd(base + 16'(i), x);
			w[i*8 +: 8] = x;
		end
	endtask

	task automatic wr32(input logic [15:0] base, input logic [31:0] w);
		for (int i = 0; i < 4; i++) begin
			wr(base + 16'(i), w[i*8 +: 8]);
		end
	endtask

	// Two snapshots exactly SPAN cycles apart see SPAN/per ticks whatever the divider phase
	task automatic rate(input logic [7:0] ctrl, input int per, input logic osc);
		wr(ADDR_CTRL_LO, ctrl);
		repeat (5) @(posedge core_clk);
		// Settled value, not the one launched at this edge
		#1 check("fast oscillator", fast_osc_enable, osc);
		rd(ADDR_COUNT, a);
		repeat (SPAN - 2) @(posedge core_clk);
		rd(ADDR_COUNT, b);
		check("ticks in span", 32'(a - b), 32'(SPAN / per));
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		mismatches = 0;
		checks = 0;
		por_n = 1'b0;
		reg_req = '0;
		repeat (5) @(posedge core_clk);
		por_n <= 1'b1;
		// Reset values and read-only places
		rd(ADDR_CTRL_LO, a);
		check("control", a, 8'h00);
		rd(ADDR_CTRL_HI, a);
		check("control high", a, 8'h00);
		rd(ADDR_KICK, a);
		check("reload strobe", a, 8'h00);
		rd32(ADDR_COUNT, v);
		check("count", v, 32'hFFFF_FFFF);
		rd32(ADDR_LOAD, v);
		check("load", v, 32'hFFFF_FFFF);
		rd(16'h300C, a);
		check("reserved", a, 8'h00);
		check("fast oscillator", fast_osc_enable, 1'b0);
		// Load copies into count, a disabled counter holds and ignores kicks
		wr32(ADDR_LOAD, 32'h0000_00F0);
		wr32(ADDR_COUNT, 32'h0000_0011);
		rd32(ADDR_COUNT, v);
		check("count after load", v, 32'h0000_00F0);
		wr(ADDR_KICK, 8'h01);
		repeat (30) @(posedge core_clk);
		rd32(ADDR_COUNT, v);
		check("count disabled", v, 32'h0000_00F0);
		// Millisecond, microsecond and speedup rates; speedup always with unit 1
		// unit with speedup
		rate(8'h01, MS_CYC, 1'b0);
		rate(8'h09, US_TICK_CYCLES, 1'b1);
		rate(8'h0D, SIM_TICK_CYCLES, 1'b1);
		// Kick while enabled reloads, and a tick may follow it
		wr(ADDR_KICK, 8'h5A);
		repeat (3) @(posedge core_clk);
		rd(ADDR_COUNT, a);
		check("kick reload", 32'(a == 8'hF0 || a == 8'hEF), 32'h0000_0001);
		wr(ADDR_LOAD, 8'h77);
		rd(ADDR_LOAD, a);
		check("load while enabled", a, 8'hF0);
		// Snapshot keeps the upper byte while the counter crosses below 100h
		wr(ADDR_CTRL_LO, 8'h00);
		wr32(ADDR_LOAD, 32'h0000_0103);
		wr(ADDR_CTRL_LO, 8'h09);
		rd(ADDR_COUNT, a);
		repeat (100) @(posedge core_clk);
		rd(ADDR_COUNT + 16'h0001, a);
		check("snapshot byte", a, 8'h01);
		rd(ADDR_COUNT, a);
		rd(ADDR_COUNT + 16'h0001, a);
		check("fresh snapshot byte", a, 8'h00);
		// Underflow forces a reset whose cause shows in the status bit
		wr(ADDR_CTRL_LO, 8'h00);
		wr32(ADDR_LOAD, 32'h0000_0005);
		wr(ADDR_CTRL_LO, 8'h09);
		n = 0;
		while (system_reset_req !== 1'b1 && n < 300) begin
			@(posedge core_clk);
			#1 n++;
		end
		check("system reset request", system_reset_req, 1'b1);
		if (n >= 300) begin
			tally_and_finish();
		end
		check("interval", 32'(n >= 55 && n <= 70), 32'h0000_0001);
		repeat (12) @(posedge core_clk);
		rd(ADDR_CTRL_LO, a);
		check("status after reset", a, 8'h02);
		// Writes are blocked while status pends; only a one clears it
		wr32(ADDR_LOAD, 32'h0000_1234);
		rd(ADDR_LOAD, a);
		check("load blocked", a, 8'hFF);
		wr(ADDR_CTRL_LO, 8'h00);
		rd(ADDR_CTRL_LO, a);
		check("status kept", a, 8'h02);
		wr(ADDR_CTRL_LO, 8'h02);
		rd(ADDR_CTRL_LO, a);
		check("status cleared", a, 8'h00);
		wr(ADDR_LOAD, 8'h34);
		rd(ADDR_LOAD, a);
		check("load unblocked", a, 8'h34);
		tally_and_finish();
	end
endmodule // tb
